// file: tcc16_regs.sv
// Implementation choice: the APB register port.
`include "tcc16_cfg.svh"

module tcc16_regs (
   input  wire logic                     clk,
   input  wire logic                     reset,
   input  wire logic                     psel,
   input  wire logic                     penable,
   input  wire logic                     pwrite,
   input  wire logic [11:0]              paddr,
   input  wire logic [31:0]              pwdata,
   input  wire logic [3:0]               pstrb,
   output logic      [31:0]              prdata,
   output logic                          pready,
   output logic                          pslverr,
   input  wire tcc16_pkg::tcc_timer_in_t timer_in,
   input  wire logic [3:0]               capture_input_pin,
   input  wire logic                     global_irq_enable,
   input  wire tcc16_pkg::tcc_ack_t      vector_ack,
   output logic [3:0]                    compare_output_pin,
   output logic [3:0]                    compare_match,
   output logic [3:0][15:0]              counter_top,
   output logic [3:0][7:0]               event_irq_req,
   output logic                          irq
);
   import tcc16_pkg::*;

   // ****************************************
   // Address decode
   // ****************************************
   function automatic tcc_dec_t decode(input logic [9:0] idx);
      tcc_dec_t d;
      d = '{kind: TCC_K_NONE, unit: 2'h0, hi: 1'b0};
      unique case (idx)
         `TCC_IDX_MASK1:    d = '{TCC_K_MASK, 2'h0, 1'b0};
         `TCC_IDX_MASK3:    d = '{TCC_K_MASK, 2'h1, 1'b0};
         `TCC_IDX_MASK4:    d = '{TCC_K_MASK, 2'h2, 1'b0};
         `TCC_IDX_MASK5:    d = '{TCC_K_MASK, 2'h3, 1'b0};
         `TCC_IDX_CAP1_LO:  d = '{TCC_K_CAP, 2'h0, 1'b0};
         `TCC_IDX_CAP1_HI:  d = '{TCC_K_CAP, 2'h0, 1'b1};
         `TCC_IDX_CAP3_LO:  d = '{TCC_K_CAP, 2'h1, 1'b0};
         `TCC_IDX_CAP3_HI:  d = '{TCC_K_CAP, 2'h1, 1'b1};
         `TCC_IDX_CAP4_LO:  d = '{TCC_K_CAP, 2'h2, 1'b0};
         `TCC_IDX_CAP4_HI:  d = '{TCC_K_CAP, 2'h2, 1'b1};
         `TCC_IDX_CAP5_LO:  d = '{TCC_K_CAP, 2'h3, 1'b0};
         `TCC_IDX_CAP5_HI:  d = '{TCC_K_CAP, 2'h3, 1'b1};
         `TCC_IDX_CMP4C_LO: d = '{TCC_K_CMP, 2'h0, 1'b0};
         `TCC_IDX_CMP4C_HI: d = '{TCC_K_CMP, 2'h0, 1'b1};
         `TCC_IDX_CMP5A_LO: d = '{TCC_K_CMP, 2'h1, 1'b0};
         `TCC_IDX_CMP5A_HI: d = '{TCC_K_CMP, 2'h1, 1'b1};
         `TCC_IDX_CMP5B_LO: d = '{TCC_K_CMP, 2'h2, 1'b0};
         `TCC_IDX_CMP5B_HI: d = '{TCC_K_CMP, 2'h2, 1'b1};
         `TCC_IDX_CMP5C_LO: d = '{TCC_K_CMP, 2'h3, 1'b0};
         `TCC_IDX_CMP5C_HI: d = '{TCC_K_CMP, 2'h3, 1'b1};
         `TCC_IDX_FLAG1:    d = '{TCC_K_FLAG, 2'h0, 1'b0};
         `TCC_IDX_FLAG3:    d = '{TCC_K_FLAG, 2'h1, 1'b0};
         `TCC_IDX_FLAG4:    d = '{TCC_K_FLAG, 2'h2, 1'b0};
         `TCC_IDX_FLAG5:    d = '{TCC_K_FLAG, 2'h3, 1'b0};
         `TCC_IDX_PINCFG:   d = '{TCC_K_PCFG, 2'h0, 1'b0};
         default:           d = '{TCC_K_NONE, 2'h0, 1'b0};
      endcase
      return d;
   endfunction

   // Compare channel k belongs to timer CMP_TMR[k], flag bit CMP_BIT[k]
   localparam logic [3:0][1:0] CMP_TMR = {2'h3, 2'h3, 2'h3, 2'h2};
   localparam logic [3:0][2:0] CMP_BIT = {`TCC_BIT_CMPC, `TCC_BIT_CMPB,
                                          `TCC_BIT_CMPA, `TCC_BIT_CMPC};

   // ****************************************
   // State
   // ****************************************
   tcc_apb_st_t      st_ff,      nxt_st;
   logic [31:0]      prdata_ff,  nxt_prdata;
   logic [7:0]       temp_ff,    nxt_temp;
   logic [7:0]       pincfg_ff,  nxt_pincfg;
   logic [3:0][7:0]  mask_ff,    nxt_mask;
   logic [3:0][7:0]  flag_ff,    nxt_flag;
   logic [3:0][15:0] cap_ff,     nxt_cap;
   logic [3:0][15:0] cmp_ff,     nxt_cmp;
   logic [3:0]       pend_ff,    nxt_pend;
   logic [3:0]       pin_ff,     nxt_pin;
   logic [3:0]       icp_ff,     nxt_icp;

   tcc_dec_t         dec;
   logic             done;
   logic             wr_en;
   logic             rd_done;
   logic [7:0]       wbyte;
   logic [3:0]       cmp_eq;
   logic [3:0]       cap_top;
   logic [3:0]       cap_evt;
   logic [3:0]       top_hit;
   logic [3:0][7:0]  evt_set;

   assign dec     = decode(paddr[11:2]);
   assign pready  = (st_ff == TCC_ST_ANS);
   assign done    = psel && penable && pready;
   assign wr_en   = done && pwrite && pstrb[0] && (dec.kind != TCC_K_NONE);
   assign rd_done = done && !pwrite;
   assign wbyte   = pwdata[7:0];
   assign pslverr = pready && (dec.kind == TCC_K_NONE);
   assign prdata  = prdata_ff;

   // ****************************************
   // Compare, capture and event sources
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_unit
         // RULE1 continuous equality
         assign cmp_eq[g] = (cmp_ff[g] == timer_in.count[CMP_TMR[g]]);
         // RULE6 capture as top
         assign cap_top[g] = (timer_in.mode[g] == `TCC_MODE_CAPTOP_A) ||
                             (timer_in.mode[g] == `TCC_MODE_CAPTOP_B);
         assign counter_top[g] = cap_top[g] ? cap_ff[g] : `TCC_FULL_TOP;
         // RULE12 capture flag sources
         assign cap_evt[g] = capture_input_pin[g] && !icp_ff[g] && !cap_top[g];
         assign top_hit[g] = cap_top[g] && timer_in.tick[g] &&
                             (timer_in.count[g] == cap_ff[g]);
         // RULE9 gated request
         assign event_irq_req[g] = flag_ff[g] & mask_ff[g] & {8{global_irq_enable}};
      end
   endgenerate

   assign compare_output_pin = pin_ff;
   assign compare_match      = pend_ff;
   assign irq                = |event_irq_req;

   always_comb begin
      evt_set = '0;
      // RULE7 flag bit positions
      for (int t = 0; t < 4; t++) begin
         evt_set[t][`TCC_BIT_OVF]  = timer_in.ovf_evt[t];
         evt_set[t][`TCC_BIT_CMPA] = timer_in.ext_cmp_evt[t][0];
         evt_set[t][`TCC_BIT_CMPB] = timer_in.ext_cmp_evt[t][1];
         evt_set[t][`TCC_BIT_CMPC] = timer_in.ext_cmp_evt[t][2];
         evt_set[t][`TCC_BIT_CAP]  = cap_evt[t] || top_hit[t];
      end
      // RULE10 flag one tick late
      for (int k = 0; k < 4; k++) begin
         if (pend_ff[k] && timer_in.tick[CMP_TMR[k]]) begin
            evt_set[CMP_TMR[k]][CMP_BIT[k]] = 1'b1;
         end
      end
   end

   // ****************************************
   // Next-state logic
   // ****************************************
   always_comb begin
      nxt_st     = st_ff;
      nxt_prdata = prdata_ff;
      nxt_temp   = temp_ff;
      nxt_pincfg = pincfg_ff;
      nxt_mask   = mask_ff;
      nxt_flag   = flag_ff;
      nxt_cap    = cap_ff;
      nxt_cmp    = cmp_ff;
      nxt_pend   = pend_ff;
      nxt_pin    = pin_ff;
      nxt_icp    = capture_input_pin;

      // One wait state so read data leaves a flip-flop
      unique case (st_ff)
         TCC_ST_IDLE: begin
            if (psel && penable) begin
               nxt_st     = TCC_ST_ANS;
               nxt_prdata = '0;
               unique case (dec.kind)
                  TCC_K_MASK: nxt_prdata[7:0] = mask_ff[dec.unit];
                  TCC_K_FLAG: nxt_prdata[7:0] = flag_ff[dec.unit];
                  TCC_K_PCFG: nxt_prdata[7:0] = pincfg_ff;
                  // RULE5 high byte from latch
                  TCC_K_CAP:  nxt_prdata[7:0] = dec.hi ? temp_ff : cap_ff[dec.unit][7:0];
                  TCC_K_CMP:  nxt_prdata[7:0] = dec.hi ? cmp_ff[dec.unit][15:8] :
                                                         cmp_ff[dec.unit][7:0];
                  TCC_K_NONE: nxt_prdata = '0;
               endcase
            end
         end
         TCC_ST_ANS: nxt_st = TCC_ST_IDLE;
      endcase

      // RULE5 low read latches high byte
      if (rd_done && dec.kind == TCC_K_CAP && !dec.hi) begin
         nxt_temp = cap_ff[dec.unit][15:8];
      end

      if (wr_en) begin
         unique case (dec.kind)
            // RULE8 reserved mask bits stay zero
            TCC_K_MASK: nxt_mask[dec.unit] = wbyte & `TCC_EVT_BITS;
            // RULE11 write one clears
            TCC_K_FLAG: nxt_flag[dec.unit] = flag_ff[dec.unit] & ~(wbyte & `TCC_EVT_BITS);
            TCC_K_PCFG: nxt_pincfg = wbyte & `TCC_PINCFG_BITS;
            // RULE4 one shared latch
            TCC_K_CAP, TCC_K_CMP: begin
               if (dec.hi) begin
                  nxt_temp = wbyte;
               end else if (dec.kind == TCC_K_CAP) begin
                  nxt_cap[dec.unit] = {temp_ff, wbyte};
               end else begin
                  // RULE3 both bytes at once
                  nxt_cmp[dec.unit] = {temp_ff, wbyte};
               end
            end
            TCC_K_NONE: nxt_pincfg = pincfg_ff;
         endcase
      end

      // RULE11 vector clears its flag
      if (vector_ack.valid) begin
         nxt_flag[vector_ack.timer][vector_ack.bit_sel] = 1'b0;
      end

      for (int t = 0; t < 4; t++) begin
         // Capture event beats a software write in the same cycle
         if (cap_evt[t]) begin
            nxt_cap[t] = timer_in.count[t];
         end
         // Set wins over any clear
         nxt_flag[t] = nxt_flag[t] | evt_set[t];
      end

      for (int k = 0; k < 4; k++) begin
         if (timer_in.tick[CMP_TMR[k]]) begin
            nxt_pend[k] = cmp_eq[k];
            // RULE2 waveform toggle on match
            if (cmp_eq[k] && pincfg_ff[k]) begin
               nxt_pin[k] = !pin_ff[k];
            end
         end
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge clk) begin
      if (reset) begin
         // RULE8 all registers reset to zero
         st_ff     <= TCC_ST_IDLE;
         prdata_ff <= '0;
         temp_ff   <= `TCC_RESET_BYTE;
         pincfg_ff <= `TCC_RESET_BYTE;
         mask_ff   <= {4{`TCC_RESET_BYTE}};
         flag_ff   <= {4{`TCC_RESET_BYTE}};
         cap_ff    <= {4{`TCC_RESET_WORD}};
         cmp_ff    <= {4{`TCC_RESET_WORD}};
         pend_ff   <= '0;
         pin_ff    <= '0;
         icp_ff    <= '0;
      end else begin
         st_ff     <= nxt_st;
         prdata_ff <= nxt_prdata;
         temp_ff   <= nxt_temp;
         pincfg_ff <= nxt_pincfg;
         mask_ff   <= nxt_mask;
         flag_ff   <= nxt_flag;
         cap_ff    <= nxt_cap;
         cmp_ff    <= nxt_cmp;
         pend_ff   <= nxt_pend;
         pin_ff    <= nxt_pin;
         icp_ff    <= nxt_icp;
      end
   end

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   logic wr_cmp5a_lo;
   logic rd_cap1_lo;
   logic wr_cap3_hi;
   assign wr_cmp5a_lo = wr_en && paddr[11:2] == `TCC_IDX_CMP5A_LO;
   assign rd_cap1_lo  = rd_done && paddr[11:2] == `TCC_IDX_CAP1_LO;
   assign wr_cap3_hi  = wr_en && paddr[11:2] == `TCC_IDX_CAP3_HI;

   // Compare match checks watch channel 0, which runs on timer 4; the compare write check watches channel 1
   a_cmp_eq_pend:     assert property (timer_in.tick[2] && cmp_eq[0] |=> pend_ff[0]) // RULE1
      else $error("match on tick did not mark pending");
   a_flag_late:       assert property (timer_in.tick[2] && pend_ff[0] // RULE10
                                       |=> flag_ff[2][3])
      else $error("compare flag not set one tick after match");
   a_pin_toggle:      assert property (timer_in.tick[2] && cmp_eq[0] && pincfg_ff[0] // RULE2
                                       |=> pin_ff[0] != $past(pin_ff[0]))
      else $error("compare pin did not toggle on match");
   a_cmp_atomic:      assert property (wr_cmp5a_lo // RULE3
                                       |=> cmp_ff[1] == {$past(temp_ff), $past(wbyte)})
      else $error("compare word not written whole");
   a_temp_shared:     assert property (wr_cap3_hi |=> temp_ff == $past(wbyte)) // RULE4
      else $error("high byte latch not loaded");
   a_cap_read_latch:  assert property (rd_cap1_lo && !(wr_en && dec.kind == TCC_K_CAP) // RULE5
                                       |=> temp_ff == $past(cap_ff[0][15:8]))
      else $error("capture high byte not latched on low read");
   a_cap_top:         assert property (cap_top[1] |-> counter_top[1] == cap_ff[1]) // RULE6
      else $error("capture value not used as top");
   a_mask_layout:     assert property (event_irq_req[0][5] == // RULE7
                                       (flag_ff[0][5] && mask_ff[0][5] && global_irq_enable))
      else $error("capture enable not at bit five");
   a_mask_resv:       assert property ((mask_ff[3] & 8'hD0) == 8'h00) // RULE8
      else $error("reserved mask bit set");
   a_irq_gate:        assert property (!global_irq_enable |-> !irq) // RULE9
      else $error("interrupt without global enable");
   a_ack_clear:       assert property (vector_ack.valid && vector_ack.timer == 2'h0 && // RULE11
                                       vector_ack.bit_sel == 3'h5 && !evt_set[0][5]
                                       |=> !flag_ff[0][5])
      else $error("vector did not clear capture flag");
   a_cap_evt:         assert property (cap_evt[0] |=> flag_ff[0][5] && // RULE12
                                       cap_ff[0] == $past(timer_in.count[0]))
      else $error("capture event not recorded");
   a_apb_wait:        assert property (psel && penable && !pready |=> pready)
      else $error("bus answer later than one wait state");
   a_ready_one:       assert property (pready |=> !pready)
      else $error("bus answer stood longer than one cycle");
   a_unmapped_err:    assert property (pready && dec.kind == TCC_K_NONE |->
                                       pslverr && prdata == 32'h00000000)
      else $error("unmapped access not refused");
   a_top_full:        assert property (!cap_top[1] |-> counter_top[1] == `TCC_FULL_TOP) // RULE6
      else $error("counter top not full scale");
   a_pend_drop:       assert property (timer_in.tick[2] && !cmp_eq[0] |=> !pend_ff[0]) // RULE1
      else $error("pending match held past a miss");
   a_pin_hold:        assert property (!timer_in.tick[2] |=> $stable(pin_ff[0])) // RULE2
      else $error("compare pin moved without a tick");
   a_w1c_clear:       assert property (wr_en && dec.kind == TCC_K_FLAG && // RULE11
                                       dec.unit == 2'h2 && wbyte[3] && !evt_set[2][3]
                                       |=> !flag_ff[2][3])
      else $error("write of one did not clear compare flag");

   // Event pulses reach their flag on the next edge; a set beats any clear
   a_evt_ovf:         assert property (timer_in.ovf_evt[3] |=> flag_ff[3][0]) // RULE7
      else $error("overflow pulse not at bit zero");
   a_ext_cmp:         assert property (timer_in.ext_cmp_evt[2][0] |=> flag_ff[2][1]) // RULE7
      else $error("compare A pulse not at bit one");
   a_top_hit:         assert property (top_hit[1] |=> flag_ff[1][5]) // RULE12
      else $error("capture top did not set capture flag");

   c_cmp_flag:  cover property (timer_in.tick[2] && pend_ff[0] ##1 flag_ff[2][3]);
   c_cap_evt:   cover property (cap_evt[0] ##1 flag_ff[0][5]);
   c_irq:       cover property (!irq ##1 irq);
   c_top_hit:   cover property (top_hit[1]);
   c_pin_flip:  cover property (timer_in.tick[2] && cmp_eq[0] && pincfg_ff[0]);
endmodule

// file: tcc16_cfg.svh
`ifndef TCC16_CFG_SVH
`define TCC16_CFG_SVH
// Function
// RULE1 - Each compare value is compared against its timer's counter value all the time.
// RULE2 - A compare match can raise a compare interrupt and toggle the compare output pin.
// RULE3 - Compare value writes pass through a high-byte latch so both bytes land together.
// RULE4 - One high-byte latch serves every 16-bit register of the block.
// RULE5 - Capture value reads use that latch so both bytes come from one captured value.
// RULE6 - The capture value serves as the counter top when the waveform mode selects it.
// RULE7 - Mask bits are capture 5, compare C 3, compare B 2, compare A 1 and overflow 0.
// RULE8 - Mask bits 7, 6 and 4 read zero and ignore writes, and every register resets to zero.
// RULE9 - An event request needs its mask bit, the global interrupt flag and its event flag.
// RULE10 - A compare flag sets on the timer tick after the tick on which the counter matched.
// RULE11 - Event flags clear when their vector executes or when software writes a one.
// RULE12 - The capture flag sets on a capture pin event or when the counter hits a capture top.

// ****************************************
// Register indexes (byte address is four times the index)
// ****************************************
`define TCC_IDX_MASK1      10'h06F
`define TCC_IDX_MASK3      10'h071
`define TCC_IDX_MASK4      10'h072
`define TCC_IDX_MASK5      10'h073
`define TCC_IDX_CAP1_LO    10'h086
`define TCC_IDX_CAP1_HI    10'h087
`define TCC_IDX_CAP3_LO    10'h096
`define TCC_IDX_CAP3_HI    10'h097
`define TCC_IDX_CAP4_LO    10'h0A6
`define TCC_IDX_CAP4_HI    10'h0A7
`define TCC_IDX_CMP4C_LO   10'h0AC
`define TCC_IDX_CMP4C_HI   10'h0AD
`define TCC_IDX_CAP5_LO    10'h126
`define TCC_IDX_CAP5_HI    10'h127
`define TCC_IDX_CMP5A_LO   10'h128
`define TCC_IDX_CMP5A_HI   10'h129
`define TCC_IDX_CMP5B_LO   10'h12A
`define TCC_IDX_CMP5B_HI   10'h12B
`define TCC_IDX_CMP5C_LO   10'h12C
`define TCC_IDX_CMP5C_HI   10'h12D
`define TCC_IDX_FLAG1      10'h140
`define TCC_IDX_FLAG3      10'h141
`define TCC_IDX_FLAG4      10'h142
`define TCC_IDX_FLAG5      10'h143
`define TCC_IDX_PINCFG     10'h144

// ****************************************
// Fields and values
// ****************************************
`define TCC_BIT_CAP        3'h5
`define TCC_BIT_CMPC       3'h3
`define TCC_BIT_CMPB       3'h2
`define TCC_BIT_CMPA       3'h1
`define TCC_BIT_OVF        3'h0
`define TCC_EVT_BITS       8'h2F
`define TCC_PINCFG_BITS    8'h0F
`define TCC_RESET_BYTE     8'h00
`define TCC_RESET_WORD     16'h0000
`define TCC_FULL_TOP       16'hFFFF
`define TCC_MODE_CAPTOP_A  4'hC
`define TCC_MODE_CAPTOP_B  4'hE
`endif

// file: tcc16_pkg.sv
package tcc16_pkg;
   typedef enum logic [2:0] {
      TCC_K_NONE = 3'b000,
      TCC_K_MASK = 3'b001,
      TCC_K_CAP  = 3'b010,
      TCC_K_CMP  = 3'b011,
      TCC_K_FLAG = 3'b100,
      TCC_K_PCFG = 3'b101
   } tcc_kind_t;

   typedef struct packed {
      tcc_kind_t  kind;
      logic [1:0] unit;
      logic       hi;
   } tcc_dec_t;

   typedef enum logic {
      TCC_ST_IDLE = 1'b0,
      TCC_ST_ANS  = 1'b1
   } tcc_apb_st_t;

   typedef struct packed {
      logic       valid;
      logic [1:0] timer;
      logic [2:0] bit_sel;
   } tcc_ack_t;

   typedef struct packed {
      logic [3:0]       tick;
      logic [3:0][15:0] count;
      logic [3:0][3:0]  mode;
      logic [3:0]       ovf_evt;
      logic [3:0][2:0]  ext_cmp_evt;
   } tcc_timer_in_t;
endpackage

// file: tcc16_cpu_model.sv
module tcc16_cpu_model (
   input  wire logic        clk,
   input  wire logic        pready,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata,
   output logic [3:0]       pstrb
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      pstrb = 4'hF;
   end

   // ****************************************
   // One transfer, held until the ready edge
   // ****************************************
   task automatic xfer(input logic w, input logic [9:0] idx, input logic [7:0] d,
                       output bit hung);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, d};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      hung = (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      // Released lines carry garbage so a slave leaning on stale values is caught
      paddr <= ~paddr;
      pwdata <= ~pwdata;
   endtask
endmodule

// file: timer16_compare_capture_regs_test.sv
`include "tcc16_cfg.svh"

module timer16_compare_capture_regs_test import tcc16_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   logic             clk, reset, psel, penable, pwrite, pready, pslverr, irq, global_irq_enable;
   logic [11:0]      paddr;
   logic [31:0]      pwdata, prdata;
   logic [3:0]       pstrb, capture_input_pin, compare_output_pin, compare_match;
   logic [3:0][15:0] counter_top;
   logic [3:0][7:0]  event_irq_req;
   tcc_timer_in_t    timer_in;
   tcc_ack_t         vector_ack;
   logic [32:0]      exp_q[$];
   int               bad_count, checks, seed;
   logic [15:0]      v;
   logic [9:0]       midx[4];
   logic [9:0]       pidx[8];

   tcc16_regs dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .timer_in(timer_in), .capture_input_pin(capture_input_pin),
      .global_irq_enable(global_irq_enable), .vector_ack(vector_ack),
      .compare_output_pin(compare_output_pin), .compare_match(compare_match),
      .counter_top(counter_top), .event_irq_req(event_irq_req), .irq(irq));

   tcc16_cpu_model cpu (.clk(clk), .pready(pready), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ****************************************
   // Checking and closing
   // ****************************************
   task automatic chk(input logic [32:0] got, input logic [32:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic conclude();
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic bus(input logic w, input logic [9:0] idx, input logic [7:0] d);
      bit hung;
      cpu.xfer(w, idx, d, hung);
      if (hung) begin
         bad_count++;
         $display("MISMATCH %0t bus hung", $time);
         conclude();
      end
   endtask

   task automatic wr(input logic [9:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d);
   endtask

   task automatic rd(input logic [9:0] idx, input logic [7:0] d, input logic err);
      exp_q.push_back({err, 24'h000000, d});
      bus(1'b0, idx, 8'h00);
   endtask

   task automatic wr16(input logic [9:0] lo, input logic [15:0] d);
      wr(lo + 10'h001, d[15:8]);
      wr(lo, d[7:0]);
   endtask

   task automatic tick(input int t, input logic [15:0] c);
      @(posedge clk);
      timer_in.tick[t] <= 1'b1;
      timer_in.count[t] <= c;
      @(posedge clk);
      timer_in.tick[t] <= 1'b0;
      #1;
   endtask

   // Read results are paired with the oldest note taken by the driver
   always @(posedge clk) begin
      if (psel && penable && pready && !pwrite) begin
         if (exp_q.size() == 0) begin
            bad_count++;
            $display("MISMATCH %0t unexpected read", $time);
         end else begin
            chk({pslverr, prdata}, exp_q.pop_front(), "read");
         end
      end
   end

   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      $display("MISMATCH %0t run too long", $time);
      conclude();
   end

   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      seed = 91;
      bad_count = 0;
      checks = 0;
      reset = 1'b1;
      global_irq_enable = 1'b0;
      capture_input_pin = 4'h0;
      timer_in = '0;
      vector_ack = '0;
      midx = '{`TCC_IDX_MASK1, `TCC_IDX_MASK3, `TCC_IDX_MASK4, `TCC_IDX_MASK5};
      pidx = '{`TCC_IDX_CAP1_LO, `TCC_IDX_CAP3_LO, `TCC_IDX_CAP4_LO, `TCC_IDX_CMP4C_LO,
               `TCC_IDX_CAP5_LO, `TCC_IDX_CMP5A_LO, `TCC_IDX_CMP5B_LO, `TCC_IDX_CMP5C_LO};
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      #1;
      chk(33'(irq), 33'h0, "irq after reset");
      for (int t = 0; t < 4; t++) begin
         rd(midx[t], 8'h00, 1'b0);
      end
      for (int i = 0; i < 8; i++) begin
         rd(pidx[i], 8'h00, 1'b0);
         rd(pidx[i] + 10'h001, 8'h00, 1'b0);
      end
      for (int t = 0; t < 4; t++) begin
         v = 16'($random(seed));
         wr(midx[t], v[7:0]);
         rd(midx[t], v[7:0] & 8'h2F, 1'b0);
      end
      v = 16'($random(seed));
      wr16(`TCC_IDX_CMP5A_LO, v);
      rd(`TCC_IDX_CMP5A_LO, v[7:0], 1'b0);
      rd(`TCC_IDX_CMP5A_HI, v[15:8], 1'b0);
      wr(`TCC_IDX_CMP5B_HI, 8'hA5);
      rd(`TCC_IDX_CMP5B_HI, 8'h00, 1'b0);
      wr(`TCC_IDX_CMP5C_LO, 8'h3C);
      rd(`TCC_IDX_CMP5C_LO, 8'h3C, 1'b0);
      rd(`TCC_IDX_CMP5C_HI, 8'hA5, 1'b0);
      v = 16'($random(seed));
      wr16(`TCC_IDX_CMP4C_LO, v);
      wr(`TCC_IDX_PINCFG, 8'h01);
      wr(midx[2], 8'h08);
      global_irq_enable <= 1'b1;
      tick(2, v);
      chk(33'(compare_match), 33'h1, "match");
      chk(33'(compare_output_pin), 33'h1, "pin toggle");
      chk(33'(irq), 33'h0, "flag too early");
      tick(2, v + 16'h0001);
      chk(33'(compare_match), 33'h0, "match held");
      chk(33'(compare_output_pin), 33'h1, "pin held");
      chk(33'(event_irq_req[2]), 33'h08, "compare request");
      chk(33'(irq), 33'h1, "irq on compare");
      rd(`TCC_IDX_FLAG4, 8'h08, 1'b0);
      wr(`TCC_IDX_FLAG4, 8'h08);
      rd(`TCC_IDX_FLAG4, 8'h00, 1'b0);
      wr(midx[0], 8'h20);
      global_irq_enable <= 1'b0;
      v = 16'($random(seed));
      @(posedge clk);
      timer_in.count[0] <= v;
      capture_input_pin[0] <= 1'b1;
      @(posedge clk);
      timer_in.count[0] <= ~v;
      @(posedge clk);
      #1;
      chk(33'(event_irq_req[0]), 33'h0, "global off");
      @(posedge clk);
      global_irq_enable <= 1'b1;
      @(posedge clk);
      #1;
      chk(33'(event_irq_req[0]), 33'h20, "capture request");
      rd(`TCC_IDX_CAP1_LO, v[7:0], 1'b0);
      rd(`TCC_IDX_CAP1_HI, v[15:8], 1'b0);
      @(posedge clk);
      vector_ack <= '{1'b1, 2'd0, 3'd5};
      capture_input_pin[0] <= 1'b0;
      @(posedge clk);
      vector_ack <= '0;
      #1;
      chk(33'(irq), 33'h0, "vector clear");
      rd(`TCC_IDX_FLAG1, 8'h00, 1'b0);
      v = 16'($random(seed));
      wr16(`TCC_IDX_CAP3_LO, v);
      for (int m = 0; m < 3; m++) begin
         @(posedge clk);
         timer_in.mode[1] <= (m == 0) ? 4'hC : ((m == 1) ? 4'hE : 4'h0);
         tick(1, v);
         chk(33'(counter_top[1]), (m == 2) ? 33'h0FFFF : 33'(v), "top");
      end
      rd(`TCC_IDX_FLAG3, 8'h20, 1'b0);
      @(posedge clk);
      timer_in.ovf_evt <= 4'hF;
      timer_in.ext_cmp_evt <= 12'h049;
      @(posedge clk);
      timer_in.ovf_evt <= 4'h0;
      timer_in.ext_cmp_evt <= 12'h000;
      for (int t = 0; t < 4; t++) begin
         rd(`TCC_IDX_FLAG1 + 10'(t), (t == 1) ? 8'h23 : ((t == 3) ? 8'h01 : 8'h03), 1'b0);
         wr(`TCC_IDX_FLAG1 + 10'(t), 8'hFF);
         rd(`TCC_IDX_FLAG1 + 10'(t), 8'h00, 1'b0);
      end
      wr(10'h000, 8'hFF);
      rd(10'h000, 8'h00, 1'b1);
      repeat (3) @(posedge clk);
      chk(33'(exp_q.size()), 33'h0, "reads left over");
      conclude();
   end
endmodule
